// ==== hw/flash_status_pkg.sv ====
// constants for the flash write-status polling controller
// assumes an asynchronous nor flash on a 16-bit data bus, driven from pclk
package flash_status_pkg;
  // status bit positions on the data bus
  localparam int unsigned POLL_BIT        = 7;
  localparam int unsigned OP_TOGGLE_BIT   = 6;
  localparam int unsigned TIMEOUT_BIT     = 5;
  localparam int unsigned ERASE_TIMER_BIT = 3;
  localparam int unsigned SEC_TOGGLE_BIT  = 2;
  // apb register offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] ADDR_OFS    = 8'h04;
  localparam logic [7:0] DATA_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h0C;
  localparam logic [7:0] RDDATA_OFS  = 8'h10;
  // ctrl fields
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_WR_BIT   = 1;
  localparam int unsigned CTRL_POLL_BIT = 2;
  localparam int unsigned CTRL_SEC_BIT  = 3;
  // status fields
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_DONE_BIT  = 1;
  localparam int unsigned ST_FAIL_BIT  = 2;
  localparam int unsigned ST_RDYBSY_BIT = 3;
  localparam int unsigned ST_ETIMER_BIT = 4;
  // strobe timing: flash cycle length, then the reset command and register default
  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned STROBE_NS   = 100;
  localparam int unsigned STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] RESET_CMD   = 16'h00F0;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
endpackage

// ==== hw/flash_bus_cycle.sv ====
// one asynchronous flash read or write cycle with chip select and strobes
// assumes the flash answers within STROBE_CYC clocks of a strobe falling
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
  import flash_status_pkg::*;
#(
  parameter int unsigned CYC = STROBE_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [21:0]      a,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n
);
  typedef enum logic [1:0] {IDLE, STROBE, RECOVER} cyc_t;
  cyc_t        st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d;
  logic [15:0] rd_q, rd_d;
  logic [21:0] a_q, a_d;
  logic [15:0] wd_q, wd_d;

  // next state: strobe low for CYC clocks, then one clock high so each read is a fresh cycle
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    a_d   = a_q;
    wd_d  = wd_q;
    unique case (st_q)
      IDLE:
      begin
        if (start)
        begin
          st_d  = STROBE;
          cnt_d = 8'(CYC);
          wr_d  = write;
          a_d   = addr;
          wd_d  = wdata;
        end
      end
      STROBE:
      begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          st_d = RECOVER;
          if (!wr_q)
            rd_d = dq_in; // sampled before oe rises
        end
      end
      RECOVER:
      begin
        st_d = IDLE;
        // back-to-back cycle: the recover clock is the only gap between strobes
        if (start)
        begin
          st_d  = STROBE;
          cnt_d = 8'(CYC);
          wr_d  = write;
          a_d   = addr;
          wd_d  = wdata;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= IDLE;
      cnt_q <= 8'h00;
      wr_q  <= 1'b0;
      rd_q  <= 16'h0000;
      a_q   <= 22'h000000;
      wd_q  <= 16'h0000;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      a_q   <= a_d;
      wd_q  <= wd_d;
    end
  end

  assign done    = (st_q == RECOVER);
  assign rdata   = rd_q;
  assign a       = a_q;
  assign dq_out  = wd_q;
  assign ce_n    = (st_q != STROBE);
  assign oe_n    = !((st_q == STROBE) && !wr_q);
  assign we_n    = !((st_q == STROBE) && wr_q);
  assign dq_oe_n = !((st_q != IDLE) && wr_q); // bus driven only across a write
endmodule
`default_nettype wire

// ==== hw/flash_status_poller.sv ====
// apb-controlled host that writes flash commands and polls write status
// assumes one flash on shared pins; software writes unlock sequences one word at a time
//
// Contract
// - host starts polling with two back-to-back full reads, compares toggle
// - no toggle change means done; next read returns array data
// - toggling with timeout high: retest; still toggling means fail, reset
// - toggling, timeout low: keep polling, or restart from first step later
// - after timeout failure host writes the reset command
// - host spacing extra erase commands under 50 us may skip timer checks
// - host confirms acceptance then checks timer flag around each command; the controller leaves both to software single reads
// - host gives a valid address when reading polling or sector toggle
`timescale 1ns/1ps
`default_nettype none
module flash_status_poller
  import flash_status_pkg::*;
#(
  parameter int unsigned CYC = STROBE_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [21:0]      flash_addr,
  input  wire logic [15:0] flash_dq_in,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic        ready_busy_n
);
  typedef enum logic [2:0] {IDLE, SINGLE, FIRST_RD, SECOND_RD, RETEST_RD, RESET_WR} poll_t;

  poll_t       st_q, st_d;
  logic [21:0] addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic        sec_q, sec_d;       // poll sector toggle instead of operation toggle
  logic        prev_q, prev_d;     // toggle bit from the previous read
  logic        busy_q, busy_d;
  logic        done_q, done_d;
  logic        fail_q, fail_d;
  logic        etimer_q, etimer_d;
  logic [15:0] rd_q, rd_d;
  logic        cyc_start, cyc_write, cyc_done;
  logic [15:0] cyc_wdata, cyc_rdata;
  logic        apb_wr, tog_bit;

  flash_bus_cycle #(.CYC(CYC)) u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cyc_start),
    .write   (cyc_write),
    .addr    (addr_q),
    .wdata   (cyc_wdata),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n),
    .a       (flash_addr),
    .dq_in   (flash_dq_in),
    .dq_out  (flash_dq_out),
    .dq_oe_n (flash_dq_oe_n)
  );

  // registers answer in the access cycle with no wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel && penable && pwrite;
  assign tog_bit = sec_q ? cyc_rdata[SEC_TOGGLE_BIT] : cyc_rdata[OP_TOGGLE_BIT];

  always_comb
  begin
    unique case (paddr)
      CTRL_OFS:   prdata = {31'h0, busy_q};
      ADDR_OFS:   prdata = {10'h000, addr_q};
      DATA_OFS:   prdata = {16'h0000, data_q};
      STATUS_OFS: prdata = {27'h0, etimer_q, ready_busy_n, fail_q, done_q, busy_q};
      RDDATA_OFS: prdata = {16'h0000, rd_q};
      default:    prdata = RESET_VALUE;
    endcase
  end

  // one sequencer: single cycles on request, or the toggle polling procedure
  always_comb
  begin
    st_d      = st_q;
    addr_d    = addr_q;
    data_d    = data_q;
    sec_d     = sec_q;
    prev_d    = prev_q;
    busy_d    = busy_q;
    done_d    = done_q;
    fail_d    = fail_q;
    etimer_d  = etimer_q;
    rd_d      = rd_q;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_wdata = data_q;
    if (apb_wr && !busy_q && paddr == ADDR_OFS)
      addr_d = pwdata[21:0];
    if (apb_wr && !busy_q && paddr == DATA_OFS)
      data_d = pwdata[15:0];
    unique case (st_q)
      IDLE:
      begin
        if (apb_wr && paddr == CTRL_OFS && pwdata[CTRL_GO_BIT])
        begin
          busy_d = 1'b1;
          done_d = 1'b0;
          fail_d = 1'b0;
          sec_d  = pwdata[CTRL_SEC_BIT];
          if (pwdata[CTRL_POLL_BIT])
            st_d = FIRST_RD;
          else
          begin
            st_d      = SINGLE;
            cyc_write = pwdata[CTRL_WR_BIT]; // command words go out at once, no added spacing
          end
          cyc_start = 1'b1;
        end
      end
      SINGLE:
      begin
        cyc_write = 1'b0;
        if (cyc_done)
        begin
          rd_d     = cyc_rdata;
          etimer_d = cyc_rdata[ERASE_TIMER_BIT];
          busy_d   = 1'b0;
          done_d   = 1'b1;
          st_d     = IDLE;
        end
      end
      FIRST_RD:
      begin
        if (cyc_done)
        begin
          prev_d    = tog_bit;
          st_d      = SECOND_RD;
          cyc_start = 1'b1;
        end
      end
      SECOND_RD, RETEST_RD:
      begin
        if (cyc_done)
        begin
          rd_d   = cyc_rdata;
          prev_d = tog_bit;
          if (tog_bit == prev_q)
          begin
            st_d   = IDLE;
            busy_d = 1'b0;
            done_d = 1'b1;
          end
          else if (st_q == RETEST_RD)
          begin
            st_d      = RESET_WR;
            cyc_start = 1'b1;
            cyc_write = 1'b1;
            cyc_wdata = RESET_CMD;
          end
          else if (cyc_rdata[TIMEOUT_BIT])
          begin
            st_d      = RETEST_RD;
            cyc_start = 1'b1;
          end
          else
          begin
            st_d      = SECOND_RD; // keep polling; the next read pairs with this one
            cyc_start = 1'b1;
          end
        end
      end
      RESET_WR:
      begin
        cyc_wdata = RESET_CMD;
        if (cyc_done)
        begin
          fail_d = 1'b1;
          busy_d = 1'b0;
          done_d = 1'b1;
          st_d   = IDLE;
        end
      end
      default: st_d = IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q     <= IDLE;
      addr_q   <= 22'h000000;
      data_q   <= 16'h0000;
      sec_q    <= 1'b0;
      prev_q   <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      fail_q   <= 1'b0;
      etimer_q <= 1'b0;
      rd_q     <= 16'h0000;
    end
    else
    begin
      st_q     <= st_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      sec_q    <= sec_d;
      prev_q   <= prev_d;
      busy_q   <= busy_d;
      done_q   <= done_d;
      fail_q   <= fail_d;
      etimer_q <= etimer_d;
      rd_q     <= rd_d;
    end
  end
endmodule
`default_nettype wire

// ==== sim/flash_status_props.sv ====
// port checker for the flash polling controller
// assumes a bind onto flash_status_poller, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module flash_status_props #(
  parameter int unsigned CYC = 2
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic [21:0] flash_addr,
  input wire logic        flash_dq_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] low_q;
  logic [7:0] low_d;
  // strobe-low clock count, the width check needs it
  always_comb low_d = flash_ce_n ? 8'h00 : low_q + 8'h01;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_q <= 8'h00;
    else low_q <= low_d;
  sequence cyc_end;
    $rose(flash_ce_n);
  endsequence
  sequence wr_pulse;
    !flash_we_n;
  endsequence
  a_apb_no_wait: assert property (psel && penable |-> pready) else $error("apb wait");
  a_no_slverr: assert property (psel && penable |-> !pslverr) else $error("apb error");
  a_strobe_width: assert property (cyc_end |-> low_q == CYC) else $error("strobe width");
  a_gap_high: assert property (cyc_end |-> flash_oe_n && flash_we_n) else $error("no gap");
  a_oe_with_ce: assert property (!flash_oe_n |-> flash_we_n && !flash_ce_n) else $error("oe");
  a_no_drive_rd: assert property (!flash_oe_n |-> flash_dq_oe_n) else $error("bus clash");
  a_write_drives: assert property (wr_pulse |-> !flash_dq_oe_n && !flash_ce_n) else $error("wr");
  a_addr_held: assert property (!flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
    else $error("addr moved");
endmodule
`default_nettype wire

// ==== sim/flash_model.sv ====
// behavioural flash status model: toggles on reads while busy
// assumes the bench arms an operation; reset command ends it only after a timeout
`timescale 1ns/1ps
`default_nettype none
module flash_model
  import flash_status_pkg::*;
#(
  parameter logic [15:0] ERASE_CMD = 16'h0030, // sector erase command code, arbitrary
  parameter int unsigned WIN_READS = 3         // acceptance window, counted in reads
)(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        arm,
  input  wire logic [7:0]  busy_reads,
  input  wire logic        fail_mode,
  output logic [15:0]      dq_in,
  output logic             ready_busy_n,
  output logic             saw_reset
);
  logic        busy_q = 1'b0;
  logic        tog_q = 1'b0;
  logic        tmo_q = 1'b0;
  logic        etf_q = 1'b1;
  logic [7:0]  left_q = 8'h00;
  logic [7:0]  win_q = 8'h00;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] st;
  initial saw_reset = 1'b0;
  // erase status: poll bit 0, timer flag from the acceptance window, both toggles on tog_q
  assign st = {8'h00, 1'b0, tog_q, tmo_q, 1'b0, etf_q, tog_q, 2'b00};
  // released bus shows the inverse of the last value, not a stale copy
  assign dq_in = (!ce_n && !oe_n) ? (busy_q ? st : addr[15:0] ^ 16'h5A3C) : ~last_q;
  assign ready_busy_n = !busy_q;
  always @(dq_in)
    if (!ce_n && !oe_n) last_q = dq_in;
  // an armed operation is an erase already past its window
  always @(posedge arm)
  begin
    busy_q = 1'b1;
    etf_q = 1'b1;
    win_q = 8'h00;
    left_q = busy_reads;
    tmo_q = 1'b0;
    saw_reset = 1'b0;
  end
  // each read end flips toggles; the window counts down first, then the erase itself
  always @(posedge oe_n)
    if (busy_q)
    begin
      tog_q = !tog_q;
      if (!etf_q)
      begin
        win_q = win_q - 8'h01;
        if (win_q == 8'h00) etf_q = 1'b1;
      end
      else
      begin
        if (left_q != 8'h00) left_q = left_q - 8'h01;
        if (left_q == 8'h00 && fail_mode) tmo_q = 1'b1;
        else if (left_q == 8'h00) busy_q = 1'b0;
      end
    end
  // commands act from the write strobe rising edge; a running erase takes another erase only inside its window, and reset only after a timeout
  always @(posedge we_n)
    if (dq_out == ERASE_CMD && (!busy_q || !etf_q))
    begin
      if (!busy_q) left_q = busy_reads;
      busy_q = 1'b1;
      etf_q = 1'b0;
      win_q = 8'(WIN_READS);
      tmo_q = 1'b0;
    end
    else if (dq_out == RESET_CMD && (tmo_q || !busy_q))
    begin
      busy_q = 1'b0;
      tmo_q = 1'b0;
      saw_reset = 1'b1;
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the flash polling controller
// assumes flash_model on the flash pins and apb tasks below
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_status_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, arm, fail_mode, rbn, saw;
  logic        ce_n, oe_n, we_n, dq_oe_n;
  logic [7:0]  paddr, busy_reads;
  logic [31:0] pwdata, prdata, r, seed, ad;
  logic [21:0] fa;
  logic [15:0] dq_in, dq_out, exp16;
  logic        et;
  int          n_errors, tests_run, w;
  // sector erase command code understood by the flash model, arbitrary
  localparam logic [15:0] ERASE_CMD = 16'h0030;
  flash_status_poller #(.CYC(2)) i_flash_status_poller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
    .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .ready_busy_n(rbn));
  flash_model #(.ERASE_CMD(ERASE_CMD), .WIN_READS(3)) i_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(fa), .dq_out(dq_out), .arm(arm),
    .busy_reads(busy_reads), .fail_mode(fail_mode), .dq_in(dq_in), .ready_busy_n(rbn), .saw_reset(saw));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // array word the flash model returns at an address when idle
  function automatic logic [15:0] arr(input logic [31:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // start a controller job and poll status until busy clears; a stuck job ends the run
  task automatic go(input logic [31:0] ctrl);
    apb(1'b1, CTRL_OFS, ctrl);
    w = 0;
    r = 32'h1;
    while (r[ST_BUSY_BIT] !== 1'b0 && w < 400)
    begin
      apb(1'b0, STATUS_OFS, 32'h0);
      w++;
    end
    if (w >= 400)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, r, 32'h0);
      n_errors++;
      wrap_up();
    end
  endtask
  // arm the model, then run a controller job
  task automatic job(input logic [7:0] n, input logic f, input logic [31:0] ctrl);
    busy_reads <= n;
    fail_mode <= f;
    arm <= 1'b1;
    apb(1'b1, ADDR_OFS, ad);
    arm <= 1'b0;
    go(ctrl);
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    #(8 * 40000);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, arm, fail_mode} = 6'h00;
    {paddr, busy_reads, pwdata} = 48'h0;
    n_errors = 0;
    tests_run = 0;
    seed = 32'hB9331451;
    et = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r, RESET_VALUE | 32'h8);
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    $display("reset test done");
    // polls: hand case of one busy read, then random lengths and addresses, both toggle bits
    for (int i = 0; i < 5; i++)
    begin
      seed = lfsr(seed);
      ad = {10'h0, seed[21:0]};
      job((i == 0) ? 8'h01 : {5'h0, seed[24:22]} + 8'h01, 1'b0, i[0] ? 32'h5 : 32'hD);
      chk(r, {27'h0, et, 4'hA});
      go(32'h1);
      apb(1'b0, RDDATA_OFS, 32'h0);
      exp16 = arr(ad);
      chk(r, {16'h0, exp16});
      et = exp16[ERASE_TIMER_BIT];
    end
    $display("poll test done");
    job(8'h01, 1'b1, 32'hD);
    chk(r, {27'h0, et, 4'hE});
    chk({31'h0, saw}, 32'h1);
    $display("fail test done");
    // erase window: a second command restarts it, then the flag rises and commands are dropped
    busy_reads <= 8'h10;
    fail_mode <= 1'b0;
    apb(1'b1, DATA_OFS, {16'h0, ERASE_CMD});
    go(32'h3);
    for (int k = 0; k < 7; k++)
    begin
      if (k == 1 || k == 5) go(32'h3);
      go(32'h1);
      chk(r, (k > 3) ? 32'h12 : 32'h02);
    end
    $display("window test done");
    job(8'hC8, 1'b0, 32'h1);
    chk(r & 32'h19, 32'h10);
    apb(1'b0, RDDATA_OFS, 32'h0);
    chk(r & 32'h88, 32'h08);
    apb(1'b1, DATA_OFS, {16'h0, RESET_CMD});
    job(8'hC8, 1'b0, 32'h3);
    chk(r & 32'h9, 32'h0);
    $display("timer test done");
    wrap_up();
  end
endmodule
bind flash_status_poller flash_status_props #(.CYC(CYC)) i_flash_status_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_oe_n(flash_dq_oe_n));
`default_nettype wire
